// [rst_map.svh]
// Register offsets, field positions, reset values and widths of the reset tracker
`ifndef RST_MAP_SVH
`define RST_MAP_SVH

// APB byte offsets
`define RST_OFF_CONTROL 12'h000
`define RST_OFF_INT_STATUS 12'h004
`define RST_OFF_INT_MASK 12'h008
`define RST_OFF_STACK 12'h00C
`define RST_OFF_TOS 12'h010
`define RST_OFF_PORT_A 12'h014
`define RST_OFF_STATE 12'h018

// Reset control and status fields; flags are cleared by their event
`define RST_BIT_BROWNOUT 0
`define RST_BIT_POWER_ON 1
`define RST_BIT_SLEEP 2
`define RST_BIT_WATCHDOG 3
`define RST_BIT_RESET_INSTR 4
`define RST_BIT_SW_BROWNOUT 6
`define RST_BIT_INT_PRIORITY 7
`define RST_FLAG_W 5
`define RST_CTRL_POR 8'h5C
`define RST_CTRL_MASK 8'hDF

// Stack register fields
`define RST_BIT_STACK_FULL 7
`define RST_BIT_STACK_UNDER 6

// Program counter, stack and vectors
`define RST_PC_W 21
`define RST_SP_W 5
`define RST_SP_MAX 5'h1F
`define RST_VEC_HIGH 21'h000008
`define RST_VEC_LOW 21'h000018

// Pin synchroniser: bit 0 power-on, bit 1 brown-out, bit 2 master clear (low active)
`define RST_SYNC_W 3
`define RST_SYNC_INIT 3'h4

// Oscillator modes that free port A bit 6; the internal I/O mode also frees bit 7
`define RST_OSC_INT_IO 4'h8
`define RST_OSC_EXT_CLK_IO 4'h4

`endif

// [rst_pkg.sv]
// Types shared by the reset source tracker
`include "rst_map.svh"
package rst_pkg;

  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_RUN,
    MODE_SLEEP
  } rst_mode_e;

  typedef struct packed {
    logic powerOn;
    logic brownout;
    logic masterClearRun;
    logic masterClearSleep;
    logic watchdog;
    logic resetInstr;
    logic stackFull;
    logic stackUnder;
  } rst_src_s;

  typedef struct packed {
    logic full;
    logic under;
    logic [`RST_SP_W-1:0] sp;
    logic [`RST_PC_W-1:0] tos;
  } rst_stack_s;

endpackage

// [rst_pin_sync.sv]
// Three-stage synchroniser with agreement filter for the reset pins
`timescale 1ns/1ps
`default_nettype none
`include "rst_map.svh"
module rst_pin_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [`RST_SYNC_W-1:0] pinIn,
  output logic [`RST_SYNC_W-1:0] pinOut
);
  localparam logic [`RST_SYNC_W-1:0] INIT = `RST_SYNC_INIT;

  genvar i;
  generate
    for (i = 0; i < `RST_SYNC_W; i = i + 1) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          s1 <= INIT[i];
          s2 <= INIT[i];
          s3 <= INIT[i];
          pinOut[i] <= INIT[i];
        end else begin
          s1 <= pinIn[i];
          s2 <= s1;
          s3 <= s2;
          // A change counts only once two stages agree
          if (s2 == s3) begin
            pinOut[i] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [rst_wake_stack.sv]
// Program counter and hardware stack state across reset and interrupt wake-up
`timescale 1ns/1ps
`default_nettype none
`include "rst_map.svh"
module rst_wake_stack (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic coreReset,
  input wire logic powerFail,
  input wire logic wakeTake,
  input wire logic wakeHighVec,
  input wire logic [`RST_PC_W-1:0] pcCurrent,
  input wire logic stackFullEvt,
  input wire logic stackUnderEvt,
  input wire logic [1:0] stackFlagClear,
  output rst_pkg::rst_stack_s stackState,
  output logic pcLoad,
  output logic [`RST_PC_W-1:0] pcLoadValue
);
  import rst_pkg::*;

  logic [`RST_PC_W-1:0] stackTos;
  logic [`RST_SP_W-1:0] stackPtr;
  logic stackFull;
  logic stackUnder;

  // One driver per field, gathered into the struct here
  assign stackState = {stackFull, stackUnder, stackPtr, stackTos};

  always_ff @(posedge core_clk) begin
    if (!nrst || coreReset) begin
      stackTos <= '0;
      stackPtr <= '0;
    end else if (wakeTake) begin
      stackTos <= pcCurrent;
      if (stackPtr != `RST_SP_MAX) begin
        stackPtr <= stackPtr + 5'h01;
      end
    end
  end

  // Stack flags survive every reset except a power failure
  always_ff @(posedge core_clk) begin
    if (!nrst || powerFail) begin
      stackFull <= 1'b0;
      stackUnder <= 1'b0;
    end else begin
      stackFull <= stackFullEvt || (wakeTake && stackPtr == `RST_SP_MAX) ||
        (stackFull && !stackFlagClear[1]);
      stackUnder <= stackUnderEvt || (stackUnder && !stackFlagClear[0]);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst || coreReset) begin
      pcLoad <= 1'b0;
      pcLoadValue <= '0;
    end else begin
      pcLoad <= wakeTake;
      if (wakeTake) begin
        pcLoadValue <= wakeHighVec ? `RST_VEC_HIGH : `RST_VEC_LOW;
      end
    end
  end
endmodule
`default_nettype wire

// [rst_source_tracking.sv]
// Reset source tracking, reset state and wake-up control with APB registers
//
// Behaviour
// - Tell apart eight distinct reset causes.
// - Low five control bits are reset flags.
// - Flag cleared by its event, software re-sets.
// - Control register holds priority and brown-out enables.
// - Interrupt wake with global enable loads vector.
// - Such wake pushes PC, advances stack pointer.
// - Wake-up sets the causing interrupt flags.
// - Unimplemented bits always read zero.
// - Port A bits 6, 7 follow oscillator mode.
`timescale 1ns/1ps
`default_nettype none
`include "rst_map.svh"
module rst_source_tracking (
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous reset pins and detectors
  input wire logic powerOnDetect,
  input wire logic brownoutDetect,
  input wire logic masterClearPin_n,
  // Same-clock reset sources and core status
  input wire logic watchdogTimeout,
  input wire logic resetInstr,
  input wire logic stackFullEvt,
  input wire logic stackUnderflowEvt,
  input wire logic sleepEnter,
  input wire logic wakeIntr,
  input wire logic wakeHighPrio,
  input wire logic [7:0] wakeFlagSrc,
  input wire logic lowPriorityGlobalEnable,
  input wire logic highPriorityGlobalEnable,
  input wire logic [`RST_PC_W-1:0] pcCurrent,
  input wire logic [3:0] oscMode,
  input wire logic [7:0] portAPins,
  input wire logic [7:0] portALatch,
  input wire logic [7:0] portADirection,
  // To the core
  output logic coreReset,
  output logic interruptPriorityEnable,
  output logic softwareBrownoutEnable,
  output logic pcLoad,
  output logic [`RST_PC_W-1:0] pcLoadValue,
  output logic [7:0] intFlagSet,
  output logic [7:0] portAPinsRead,
  output logic [7:0] portALatchRead,
  output logic [7:0] portADirectionRead,
  output logic [1:0] portAUpperEnable,
  output logic irq
);
  import rst_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and event detection

  logic [`RST_SYNC_W-1:0] pinSync;
  logic [`RST_SYNC_W-1:0] pinPrev;
  rst_mode_e mode;
  rst_src_s src;
  logic masterClearFall;
  logic resetHeld;
  logic powerFail;
  logic anyReset;
  logic sleeping;
  logic wakeEvt;
  logic wakeTake;

  rst_pin_sync u_pin_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .pinIn({masterClearPin_n, brownoutDetect, powerOnDetect}),
    .pinOut(pinSync)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinPrev <= `RST_SYNC_INIT;
    end else begin
      pinPrev <= pinSync;
    end
  end

  assign sleeping = (mode == MODE_SLEEP);
  assign masterClearFall = !pinSync[2] && pinPrev[2];

  // Watchdog in sleep wakes the core instead of resetting it
  always_comb begin
    src.powerOn = pinSync[0] && !pinPrev[0];
    src.brownout = pinSync[1] && !pinPrev[1];
    src.masterClearRun = masterClearFall && !sleeping;
    src.masterClearSleep = masterClearFall && sleeping;
    src.watchdog = watchdogTimeout && !sleeping;
    src.resetInstr = resetInstr;
    src.stackFull = stackFullEvt;
    src.stackUnder = stackUnderflowEvt;
  end

  assign powerFail = pinSync[0] || pinSync[1];
  assign resetHeld = powerFail || !pinSync[2];
  assign anyReset = (|src) || resetHeld;
  assign wakeEvt = sleeping && !anyReset && (wakeIntr || watchdogTimeout);
  assign wakeTake = wakeEvt && wakeIntr && (lowPriorityGlobalEnable || highPriorityGlobalEnable);

  //////////////////////////////////////////////////////////////////////////////
  // Reset state

  // Held for as long as any source stays asserted
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      coreReset <= 1'b1;
    end else begin
      coreReset <= anyReset;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mode <= MODE_RESET;
    end else begin
      case (mode)
        MODE_RESET: begin
          if (!anyReset) begin
            mode <= MODE_RUN;
          end
        end
        MODE_RUN: begin
          if (anyReset) begin
            mode <= MODE_RESET;
          end else if (sleepEnter) begin
            mode <= MODE_SLEEP;
          end
        end
        MODE_SLEEP: begin
          if (anyReset) begin
            mode <= MODE_RESET;
          end else if (wakeIntr || watchdogTimeout) begin
            mode <= MODE_RUN;
          end
        end
        default: begin
          mode <= MODE_RESET;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic setup;
  logic access;
  logic wrCtrl;
  logic wrIntStat;
  logic wrIntMask;
  logic wrStack;
  logic hit;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wrCtrl = access && pwrite && paddr == `RST_OFF_CONTROL;
  assign wrIntStat = access && pwrite && paddr == `RST_OFF_INT_STATUS;
  assign wrIntMask = access && pwrite && paddr == `RST_OFF_INT_MASK;
  assign wrStack = access && pwrite && paddr == `RST_OFF_STACK;

  always_comb begin
    case (paddr)
      `RST_OFF_CONTROL, `RST_OFF_INT_STATUS, `RST_OFF_INT_MASK, `RST_OFF_STACK,
      `RST_OFF_TOS, `RST_OFF_PORT_A, `RST_OFF_STATE: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access && !hit;

  //////////////////////////////////////////////////////////////////////////////
  // Reset control and status register

  logic [7:0] ctrl;
  logic [7:0] next_ctrl;

  // Hardware events are applied after the write, so an event wins over a re-set
  always_comb begin
    next_ctrl = ctrl;
    if (wrCtrl) begin
      next_ctrl[`RST_FLAG_W-1:0] = ctrl[`RST_FLAG_W-1:0] | pwdata[`RST_FLAG_W-1:0];
      next_ctrl[`RST_BIT_INT_PRIORITY] = pwdata[`RST_BIT_INT_PRIORITY];
      next_ctrl[`RST_BIT_SW_BROWNOUT] = pwdata[`RST_BIT_SW_BROWNOUT];
    end
    if (sleepEnter && mode == MODE_RUN) begin
      next_ctrl[`RST_BIT_SLEEP] = 1'b0;
      next_ctrl[`RST_BIT_WATCHDOG] = 1'b1;
    end
    if (wakeEvt && !wakeIntr) begin
      next_ctrl[`RST_BIT_WATCHDOG] = 1'b0;
    end
    if (src.watchdog) begin
      next_ctrl[`RST_BIT_WATCHDOG] = 1'b0;
      next_ctrl[`RST_BIT_SLEEP] = 1'b1;
    end
    if (src.masterClearSleep) begin
      next_ctrl[`RST_BIT_SLEEP] = 1'b0;
    end
    if (src.resetInstr) begin
      next_ctrl[`RST_BIT_RESET_INSTR] = 1'b0;
    end
    if (src.brownout) begin
      next_ctrl[`RST_BIT_BROWNOUT] = 1'b0;
      next_ctrl[`RST_BIT_SLEEP] = 1'b1;
      next_ctrl[`RST_BIT_WATCHDOG] = 1'b1;
    end
    if (src.powerOn) begin
      next_ctrl = `RST_CTRL_POR;
    end
    if (anyReset) begin
      next_ctrl[`RST_BIT_INT_PRIORITY] = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ctrl <= `RST_CTRL_POR;
    end else begin
      ctrl <= next_ctrl & `RST_CTRL_MASK;
    end
  end

  assign interruptPriorityEnable = ctrl[`RST_BIT_INT_PRIORITY];
  assign softwareBrownoutEnable = ctrl[`RST_BIT_SW_BROWNOUT];

  //////////////////////////////////////////////////////////////////////////////
  // Reset-cause interrupt: sticky status, mask, level output

  logic [7:0] intStat;
  logic [7:0] intMask;

  // Set wins over the write-one clear
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      intStat <= 8'h00;
    end else begin
      intStat <= (intStat & ~(wrIntStat ? pwdata[7:0] : 8'h00)) | src;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      intMask <= 8'h00;
    end else if (wrIntMask) begin
      intMask <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat & intMask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wake-up: vector, stack push and interrupt flags

  rst_stack_s stackState;

  rst_wake_stack u_wake_stack (
    .core_clk(core_clk),
    .nrst(nrst),
    .coreReset(coreReset),
    .powerFail(powerFail),
    .wakeTake(wakeTake),
    .wakeHighVec(!ctrl[`RST_BIT_INT_PRIORITY] || wakeHighPrio),
    .pcCurrent(pcCurrent),
    .stackFullEvt(stackFullEvt),
    .stackUnderEvt(stackUnderflowEvt),
    .stackFlagClear(wrStack ? {pwdata[`RST_BIT_STACK_FULL], pwdata[`RST_BIT_STACK_UNDER]} : 2'h0),
    .stackState(stackState),
    .pcLoad(pcLoad),
    .pcLoadValue(pcLoadValue)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst || coreReset) begin
      intFlagSet <= 8'h00;
    end else begin
      intFlagSet <= wakeEvt ? wakeFlagSrc : 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port A read masking for the oscillator pins

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      portAUpperEnable <= 2'h0;
    end else begin
      portAUpperEnable[0] <= oscMode == `RST_OSC_INT_IO || oscMode == `RST_OSC_EXT_CLK_IO;
      portAUpperEnable[1] <= oscMode == `RST_OSC_INT_IO;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_port_a
      logic bitEn;
      if (b < 6) begin : g_low
        assign bitEn = 1'b1;
      end else begin : g_high
        assign bitEn = portAUpperEnable[b-6];
      end
      always_ff @(posedge core_clk) begin
        if (!nrst) begin
          portAPinsRead[b] <= 1'b0;
          portALatchRead[b] <= 1'b0;
          portADirectionRead[b] <= 1'b0;
        end else begin
          portAPinsRead[b] <= portAPins[b] && bitEn;
          portALatchRead[b] <= portALatch[b] && bitEn;
          portADirectionRead[b] <= portADirection[b] && bitEn;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup phase

  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h00000000;
    case (paddr)
      `RST_OFF_CONTROL: readMux = {24'h000000, ctrl & `RST_CTRL_MASK};
      `RST_OFF_INT_STATUS: readMux = {24'h000000, intStat};
      `RST_OFF_INT_MASK: readMux = {24'h000000, intMask};
      `RST_OFF_STACK: readMux = {24'h000000, stackState.full, stackState.under, 1'b0, stackState.sp};
      `RST_OFF_TOS: readMux = {11'h000, stackState.tos};
      `RST_OFF_PORT_A: readMux = {8'h00, portADirectionRead, portALatchRead, portAPinsRead};
      `RST_OFF_STATE: readMux = {28'h0000000, portAUpperEnable, sleeping, coreReset};
      default: readMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= readMux;
    end
  end

endmodule
`default_nettype wire

// [rst_core_model.sv]
// Behavioural core model: program counter driven from the tracker outputs
`timescale 1ns/1ps
`default_nettype none
`include "rst_map.svh"
module rst_core_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic coreReset,
  input wire logic pcLoad,
  input wire logic [`RST_PC_W-1:0] pcLoadValue,
  output logic [`RST_PC_W-1:0] pcCurrent
);
  ////////////////////////////////////////////////////////////
  // Runs on by one instruction word unless reset or redirected
  always_ff @(posedge core_clk) begin
    if (!nrst || coreReset) begin
      pcCurrent <= '0;
    end else if (pcLoad) begin
      pcCurrent <= pcLoadValue;
    end else begin
      pcCurrent <= pcCurrent + 21'h2;
    end
  end
endmodule
`default_nettype wire

// [rst_source_tracking_props.sv]
// Port assertions for the reset source tracker
`timescale 1ns/1ps
`default_nettype none
`include "rst_map.svh"
module rst_source_tracking_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic powerOnDetect,
  input wire logic brownoutDetect,
  input wire logic masterClearPin_n,
  input wire logic watchdogTimeout,
  input wire logic resetInstr,
  input wire logic stackFullEvt,
  input wire logic stackUnderflowEvt,
  input wire logic wakeIntr,
  input wire logic wakeHighPrio,
  input wire logic lowPriorityGlobalEnable,
  input wire logic highPriorityGlobalEnable,
  input wire logic coreReset,
  input wire logic interruptPriorityEnable,
  input wire logic pcLoad,
  input wire logic [`RST_PC_W-1:0] pcLoadValue
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////
  // Long enough to cover the pin synchroniser
  sequence pinHeld;
    (!masterClearPin_n || powerOnDetect || brownoutDetect) [*7];
  endsequence
  sequence allQuiet;
    (masterClearPin_n && !powerOnDetect && !brownoutDetect && !watchdogTimeout && !resetInstr
      && !stackFullEvt && !stackUnderflowEvt) [*8];
  endsequence
  ////////////////////////////////////////////////////////////
  a_pin_reset: assert property (pinHeld |-> coreReset)
    else $error("core reset low while a reset pin is held");
  a_reset_release: assert property (allQuiet |-> !coreReset)
    else $error("core reset stuck with all sources quiet");
  a_core_event: assert property ((resetInstr || stackFullEvt || stackUnderflowEvt) |=> coreReset)
    else $error("core event gave no reset");
  a_apb_answer: assert property (psel && penable && paddr[1:0] == 2'h0 |->
    pready && (pslverr == (paddr > `RST_OFF_STATE)))
    else $error("wrong bus answer");
  a_vector_select: assert property (pcLoad |-> pcLoadValue ==
    (($past(interruptPriorityEnable) && !$past(wakeHighPrio)) ? `RST_VEC_LOW : `RST_VEC_HIGH))
    else $error("wrong wake vector");
  a_vector_cause: assert property (pcLoad |-> $past(wakeIntr) &&
    ($past(lowPriorityGlobalEnable) || $past(highPriorityGlobalEnable)))
    else $error("vector load without enabled interrupt wake");
  a_load_pulse: assert property (pcLoad |=> !pcLoad)
    else $error("vector load longer than one cycle");
  a_priority_clear: assert property (coreReset && !(psel && penable && pwrite) |=> !interruptPriorityEnable)
    else $error("priority enable survived a reset");
endmodule
bind rst_source_tracking rst_source_tracking_props u_props (
  .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .powerOnDetect, .brownoutDetect,
  .masterClearPin_n, .watchdogTimeout, .resetInstr, .stackFullEvt, .stackUnderflowEvt, .wakeIntr, .wakeHighPrio,
  .lowPriorityGlobalEnable, .highPriorityGlobalEnable, .coreReset, .interruptPriorityEnable, .pcLoad, .pcLoadValue
);
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the reset source tracker
`timescale 1ns/1ps
`default_nettype none
`include "rst_map.svh"
module testbench;
  import rst_pkg::*;
  logic core_clk = 1'h0;
  logic nrst, psel, penable, pwrite, pready, pslverr, err, ipe, hp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata, rnd;
  logic powerOnDetect, brownoutDetect, masterClearPin_n, watchdogTimeout, resetInstr, stackFullEvt;
  logic stackUnderflowEvt, sleepEnter, wakeIntr, wakeHighPrio, lowPriorityGlobalEnable, highPriorityGlobalEnable;
  logic [7:0] wakeFlagSrc, portAPins, portALatch, portADirection, intFlagSet, src, mask, m;
  logic [7:0] portAPinsRead, portALatchRead, portADirectionRead;
  logic [3:0] oscMode;
  logic [4:0] sp0;
  logic [1:0] portAUpperEnable, gie;
  logic [`RST_PC_W-1:0] pcCurrent, pcLoadValue, pcSeen;
  logic coreReset, interruptPriorityEnable, softwareBrownoutEnable, pcLoad, irq;
  integer seed = 32'h0440;
  int n_errors = 0;
  int n_tests = 0;
  logic [11:0] offs [5] = '{`RST_OFF_CONTROL, `RST_OFF_INT_STATUS, `RST_OFF_INT_MASK, `RST_OFF_STACK, `RST_OFF_TOS};
  always #5 core_clk = ~core_clk;
  rst_source_tracking DUT (
    .core_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .powerOnDetect, .brownoutDetect, .masterClearPin_n, .watchdogTimeout, .resetInstr, .stackFullEvt,
    .stackUnderflowEvt, .sleepEnter, .wakeIntr, .wakeHighPrio, .wakeFlagSrc, .lowPriorityGlobalEnable,
    .highPriorityGlobalEnable, .pcCurrent, .oscMode, .portAPins, .portALatch, .portADirection, .coreReset,
    .interruptPriorityEnable, .softwareBrownoutEnable, .pcLoad, .pcLoadValue, .intFlagSet, .portAPinsRead,
    .portALatchRead, .portADirectionRead, .portAUpperEnable, .irq
  );
  rst_core_model core (.core_clk, .nrst, .coreReset, .pcLoad, .pcLoadValue, .pcCurrent);
  ////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Starts one edge late so psel never toggles twice in a time step
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do @(posedge core_clk); while (pready !== 1'h1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    check(nm, rdata, e);
  endtask
  task automatic idle_src;
    {powerOnDetect, brownoutDetect, watchdogTimeout, resetInstr, stackFullEvt, stackUnderflowEvt} <= '0;
    masterClearPin_n <= 1'h1;
  endtask
  // Sources in status bit order, highest first; pins held past the synchroniser
  task automatic fire(input int i);
    if (i == 3) begin
      @(posedge core_clk);
      sleepEnter <= 1'h1;
      @(posedge core_clk);
      sleepEnter <= 1'h0;
    end
    @(posedge core_clk);
    case (i)
      0: powerOnDetect <= 1'h1;
      1: brownoutDetect <= 1'h1;
      2, 3: masterClearPin_n <= 1'h0;
      4: watchdogTimeout <= 1'h1;
      5: resetInstr <= 1'h1;
      6: stackFullEvt <= 1'h1;
      default: stackUnderflowEvt <= 1'h1;
    endcase
    repeat (i < 4 ? 10 : 1) @(posedge core_clk);
    if (i < 4) check("core reset held", coreReset, 32'h1);
    idle_src();
    repeat (2) @(posedge core_clk);
    for (int k = 0; k < 40 && coreReset !== 1'h0; k++) @(posedge core_clk);
  endtask
  // Control value after each source, starting from 0xDF
  function automatic logic [31:0] exp_ctrl(input int i);
    case (i)
      0: return {24'h0, `RST_CTRL_POR};
      1: return 32'h5E;
      3: return 32'h5B;
      4: return 32'h57;
      5: return 32'h4F;
      default: return 32'h5F;
    endcase
  endfunction
  task automatic give_verdict;
    $display("Checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end
  initial begin
    nrst <= 1'h0;
    idle_src();
    {psel, penable, pwrite, sleepEnter, wakeIntr, wakeHighPrio, lowPriorityGlobalEnable} <= '0;
    {highPriorityGlobalEnable, paddr, pwdata, wakeFlagSrc, oscMode, portAPins, portALatch, portADirection} <= '0;
    repeat (16) @(posedge core_clk);
    nrst <= 1'h1;
    for (int k = 0; k < 40 && coreReset !== 1'h0; k++) @(posedge core_clk);
    for (int k = 0; k < 5; k++) rd_chk("reset value", offs[k], k == 0 ? {24'h0, `RST_CTRL_POR} : 32'h0);
    apb(1'h1, `RST_OFF_CONTROL, 32'hFF);
    rd_chk("control unused bit", `RST_OFF_CONTROL, 32'hDF);
    apb(1'h0, 12'h01C, 32'h0);
    check("unmapped error", err, 32'h1);
    check("unmapped data", rdata, 32'h0);
    $display("registers test done");
    for (int i = 0; i < 8; i++) begin
      apb(1'h1, `RST_OFF_CONTROL, 32'hDF);
      fire(i);
      mask = $random(seed);
      apb(1'h1, `RST_OFF_INT_MASK, {24'h0, mask});
      rd_chk("control flags", `RST_OFF_CONTROL, exp_ctrl(i));
      check("priority enable", interruptPriorityEnable, 32'h0);
      check("sw brownout", softwareBrownoutEnable, 32'h1);
      rd_chk("cause", `RST_OFF_INT_STATUS, 32'h80 >> i);
      check("irq", irq, |(mask & (8'h80 >> i)));
      rd_chk("stack flags", `RST_OFF_STACK, i == 6 ? 32'h80 : (i == 7 ? 32'h40 : 32'h0));
      apb(1'h1, `RST_OFF_INT_STATUS, 32'hFF);
      apb(1'h1, `RST_OFF_STACK, 32'hC0);
      repeat (2) @(posedge core_clk);
      check("irq cleared", irq, 32'h0);
      $display("source %0d test done", i);
    end
    for (int k = 0; k < 5; k++) begin
      ipe = $random(seed);
      hp = $random(seed);
      src = $random(seed);
      gie = $random(seed);
      apb(1'h1, `RST_OFF_CONTROL, {24'h0, ipe, 7'h5F});
      apb(1'h0, `RST_OFF_STACK, 32'h0);
      sp0 = rdata[4:0];
      @(posedge core_clk);
      sleepEnter <= 1'h1;
      @(posedge core_clk);
      sleepEnter <= 1'h0;
      wakeHighPrio <= hp;
      wakeFlagSrc <= src;
      {lowPriorityGlobalEnable, highPriorityGlobalEnable} <= (gie == 2'h0) ? 2'h3 : gie;
      if (k < 4) wakeIntr <= 1'h1;
      else watchdogTimeout <= 1'h1;
      @(posedge core_clk);
      pcSeen = pcCurrent;
      wakeIntr <= 1'h0;
      watchdogTimeout <= 1'h0;
      @(posedge core_clk);
      check("vector load", pcLoad, k < 4);
      check("wake flags", intFlagSet, src);
      if (k < 4) begin
        check("vector", pcLoadValue, (ipe && !hp) ? `RST_VEC_LOW : `RST_VEC_HIGH);
        rd_chk("pushed pc", `RST_OFF_TOS, pcSeen);
        rd_chk("stack pointer", `RST_OFF_STACK, sp0 + 5'h1);
      end else begin
        rd_chk("watchdog wake flags", `RST_OFF_CONTROL, {24'h0, ipe, 7'h53});
      end
    end
    $display("wake test done");
    for (int k = 0; k < 3; k++) begin
      oscMode <= (k == 0) ? `RST_OSC_INT_IO : ((k == 1) ? `RST_OSC_EXT_CLK_IO : 4'h0);
      rnd = $random(seed);
      {portADirection, portALatch, portAPins} <= rnd[23:0];
      repeat (2) @(posedge core_clk);
      m = {k == 0, k < 2, 6'h3F};
      rd_chk("port a", `RST_OFF_PORT_A, {8'h0, rnd[23:16] & m, rnd[15:8] & m, rnd[7:0] & m});
      check("pins read", portAPinsRead, rnd[7:0] & m);
      check("latch read", portALatchRead, rnd[15:8] & m);
      check("direction read", portADirectionRead, rnd[23:16] & m);
      apb(1'h0, `RST_OFF_STATE, 32'h0);
      check("upper enable", rdata[3:2], m[7:6]);
    end
    $display("port test done");
    give_verdict();
  end
endmodule
`default_nettype wire
